// file: caf_pkg.sv
// Purpose: Shared constants for the CAN acceptance filter control block
// Assumes: 32-bit APB, two register words (control and status)
// Notes:   Four filters share one byte layout
package caf_pkg;
   localparam int          NUM_FILTERS     = 4;
   localparam int          FIRST_FILTER    = 16;
   localparam int          FLT_BYTE_W      = 8;
   localparam int          EN_POS          = 7;
   localparam int          MSEL_LSB        = 5;
   localparam int          MSEL_W          = 2;
   localparam int          FSEL_LSB        = 0;
   localparam int          FSEL_W          = 5;
   localparam logic [11:0] CTRL_OFFSET     = 12'h000;
   localparam logic [11:0] STATUS_OFFSET   = 12'h004;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   localparam logic [31:0] RDZERO          = 32'h0000_0000;

   typedef logic [FLT_BYTE_W-1:0] caf_byte_type;

   typedef struct packed {
      logic [MSEL_W-1:0] mask_sel;
      logic [FSEL_W-1:0] fifo_sel;
      logic              enable;
   } caf_filter_type;

   function automatic caf_filter_type caf_decode(input caf_byte_type b);
      caf_filter_type f;
      f.enable   = b[EN_POS];
      f.mask_sel = b[MSEL_LSB +: MSEL_W];
      f.fifo_sel = b[FSEL_LSB +: FSEL_W];
      return f;
   endfunction
endpackage

// file: caf_byte_if.sv
// Purpose: Carries one filter byte write request and the held byte
// Assumes: Single clock
// Notes:   Used between top and byte slice
interface caf_byte_if;
   logic                 wr;
   logic [7:0]           wdata;
   logic [7:0]           value;
   logic                 blocked;
   modport ctrl (output wr, output wdata, input value, input blocked);
   modport slice (input wr, input wdata, output value, output blocked);
endinterface

// file: caf_filter_slice.sv
// Purpose: Holds one filter control byte and guards its configuration
// Assumes: Writes come pre-decoded from the bus slave
// Notes:   Enable bit is always writable
module caf_filter_slice
   import caf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   caf_byte_if.slice bif
);
   typedef struct packed {
      logic [7:0] val;
      logic       blk;
   } caf_slice_state_type;

   caf_slice_state_type s_q;
   caf_slice_state_type s_d;

   always_comb begin
      s_d     = s_q;
      s_d.blk = 1'b0;
      if (bif.wr) begin
         s_d.val[EN_POS] = bif.wdata[EN_POS];
         if (!s_q.val[EN_POS]) begin
            s_d.val[EN_POS-1:0] = bif.wdata[EN_POS-1:0];
         end else if (bif.wdata[EN_POS-1:0] != s_q.val[EN_POS-1:0]) begin
            s_d.blk = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign bif.value   = s_q.val;
   assign bif.blocked = s_q.blk;

   property p_cfg_locked;
      @(posedge pclk) disable iff (!presetn)
      $past(s_q.val[EN_POS]) && $past(bif.wr) |-> s_q.val[6:0] == $past(s_q.val[6:0]);
   endproperty
   a_cfg_locked: assert property (p_cfg_locked) else $error("Config changed while enabled");

   property p_cfg_open;
      @(posedge pclk) disable iff (!presetn)
      !s_q.val[EN_POS] && bif.wr |=> s_q.val == $past(bif.wdata);
   endproperty
   a_cfg_open: assert property (p_cfg_open) else $error("Write lost while disabled");
endmodule // caf_filter_slice

// file: caf_filter_ctrl.sv
// Purpose: APB control register for acceptance filters 16 to 19
// Assumes: APB3 slave, zero wait states, 32-bit data
// Notes:   Outputs feed the match engine and receive FIFOs
//
// Operation
// - Bit 31 enables filter 19; clear means it accepts nothing.
// - Bits 30-29 choose acceptance mask 0 to 3 for filter 19.
// - Bits 28-24 name the receive FIFO 0 to 31 for filter 19.
// - Filter 18 uses bits 23, 22-21 and 20-16 the same way.
// - Mask and FIFO fields change only while that filter is disabled.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
module caf_filter_ctrl
   import caf_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   output logic [3:0]       per_filter_enable,
   output logic [7:0]       filter_mask_select,
   output logic [19:0]      filter_fifo_select
);
   import caf_pkg::*;

   typedef struct packed {
      logic [31:0] rdata;
      logic [3:0]  en;
      logic [7:0]  msel;
      logic [19:0] fsel;
      logic [3:0]  locked_sticky;
   } caf_top_state_type;

   caf_top_state_type st_q;
   caf_top_state_type st_d;
   logic [31:0]       ctrl_word;
   logic [3:0]        blk_vec;
   logic              acc;
   logic              wr_ctrl;

   assign acc     = psel && penable;
   assign wr_ctrl = acc && pwrite && (paddr == CTRL_OFFSET);

   genvar g;
   generate
      for (g = 0; g < NUM_FILTERS; g++) begin : g_flt
         caf_byte_if bif ();
         assign bif.wr    = wr_ctrl;
         assign bif.wdata = pwdata[g*FLT_BYTE_W +: FLT_BYTE_W];
         assign ctrl_word[g*FLT_BYTE_W +: FLT_BYTE_W] = bif.value;
         assign blk_vec[g] = bif.blocked;
         caf_filter_slice u_slice (
            .pclk    (pclk),
            .presetn (presetn),
            .bif     (bif)
         );
      end
   endgenerate

   always_comb begin
      caf_filter_type f;
      f     = '0;
      st_d  = st_q;
      for (int i = 0; i < NUM_FILTERS; i++) begin
         f = caf_decode(ctrl_word[i*FLT_BYTE_W +: FLT_BYTE_W]);
         st_d.en[i]              = f.enable;
         st_d.msel[i*2 +: 2]     = f.mask_sel;
         st_d.fsel[i*5 +: 5]     = f.fifo_sel;
      end
      st_d.locked_sticky = st_q.locked_sticky | blk_vec;
      if (acc && pwrite && paddr == STATUS_OFFSET) begin
         st_d.locked_sticky = blk_vec | (st_q.locked_sticky & ~pwdata[3:0]);
      end
      st_d.rdata = RDZERO;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            CTRL_OFFSET:   st_d.rdata = ctrl_word;
            STATUS_OFFSET: st_d.rdata = {28'h0000000, st_d.locked_sticky};
            default:       st_d.rdata = RDZERO;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pready             = 1'b1;
   assign pslverr            = 1'b0;
   assign prdata             = st_q.rdata;
   assign per_filter_enable  = st_q.en;
   assign filter_mask_select = st_q.msel;
   assign filter_fifo_select = st_q.fsel;

   property p_en_follows;
      @(posedge pclk) disable iff (!presetn)
      ##1 per_filter_enable[3] == $past(ctrl_word[31]);
   endproperty
   a_en_follows: assert property (p_en_follows) else $error("Filter 19 enable mismatch");

   property p_filter19_mask_select;
      @(posedge pclk) disable iff (!presetn)
      ##1 filter_mask_select[7:6] == $past(ctrl_word[30:29]);
   endproperty
   a_filter19_mask_select: assert property (p_filter19_mask_select) else $error("Filter 19 mask select mismatch");

   property p_filter19_fifo_select;
      @(posedge pclk) disable iff (!presetn)
      ##1 filter_fifo_select[19:15] == $past(ctrl_word[28:24]);
   endproperty
   a_filter19_fifo_select: assert property (p_filter19_fifo_select) else $error("Filter 19 FIFO select mismatch");

   property p_f18;
      @(posedge pclk) disable iff (!presetn)
      ##1 {per_filter_enable[2], filter_mask_select[5:4], filter_fifo_select[14:10]}
          == $past(ctrl_word[23:16]);
   endproperty
   a_f18: assert property (p_f18) else $error("Filter 18 fields mismatch");

   property p_lo;
      @(posedge pclk) disable iff (!presetn)
      ##1 {per_filter_enable[1], filter_mask_select[3:2], filter_fifo_select[9:5]}
          == $past(ctrl_word[15:8]);
   endproperty
   a_lo: assert property (p_lo) else $error("Filter 17 fields mismatch");

   property p_f16;
      @(posedge pclk) disable iff (!presetn)
      ##1 {per_filter_enable[0], filter_mask_select[1:0], filter_fifo_select[4:0]}
          == $past(ctrl_word[7:0]);
   endproperty
   a_f16: assert property (p_f16) else $error("Filter 16 fields mismatch");

   // A refused write must show in the sticky flags even against a clear
   property p_sticky_set;
      @(posedge pclk) disable iff (!presetn)
      (|blk_vec) |=> (st_q.locked_sticky & $past(blk_vec)) == $past(blk_vec);
   endproperty
   a_sticky_set: assert property (p_sticky_set) else $error("Refused write not flagged");

   sequence s_wr_enabled;
      wr_ctrl && ctrl_word[31];
   endsequence
   property p_lock19;
      @(posedge pclk) disable iff (!presetn)
      s_wr_enabled ##1 1'b1 |-> ctrl_word[30:24] == $past(ctrl_word[30:24]);
   endproperty
   a_lock19: assert property (p_lock19) else $error("Filter 19 changed while enabled");
endmodule // caf_filter_ctrl

// file: caf_match_model.sv
// Purpose: Match engine view of one acceptance filter
// Assumes: Fed by the filter control outputs
// Notes:   Behavioural; sel picks filter 16 plus sel
module caf_match_model (
   input  wire logic [3:0]  per_filter_enable,
   input  wire logic [7:0]  filter_mask_select,
   input  wire logic [19:0] filter_fifo_select,
   input  wire logic [1:0]  sel,
   output logic             accept,
   output logic [1:0]       mask,
   output logic [4:0]       fifo
);
   timeunit 1ns;
   timeprecision 1ps;
   assign accept = per_filter_enable[sel];
   assign mask   = filter_mask_select[sel*2 +: 2];
   assign fifo   = filter_fifo_select[sel*5 +: 5];
endmodule // caf_match_model

// file: caf_filter_ctrl_tb.sv
// Purpose: Self-checking bench for the filter control register
// Assumes: Zero-wait APB slave, outputs lag writes by 2 edges
// Notes:   Locked fields of enabled filters are probed
module caf_filter_ctrl_tb;
   import caf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, accept;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  fen;
   logic [7:0]  fmask;
   logic [19:0] ffifo;
   logic [1:0]  sel, mask;
   logic [4:0]  fifo;
   logic        slv;
   int          error_cnt = 0;
   int          checks = 0;
   caf_filter_ctrl caf_filter_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .per_filter_enable(fen),
      .filter_mask_select(fmask), .filter_fifo_select(ffifo));
   caf_match_model caf_match_model_inst (.per_filter_enable(fen), .filter_mask_select(fmask),
      .filter_fifo_select(ffifo), .sel(sel), .accept(accept), .mask(mask), .fifo(fifo));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic report_and_stop();
      if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Starts just after a rising edge, holds until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         report_and_stop();
      end
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr_chk(input logic [31:0] d, input logic [31:0] e);
      apb(1'b1, CTRL_OFFSET, d);
      repeat (2) @(posedge pclk);
      for (int i = 0; i < 4; i++) begin
         #1 sel = 2'(i);
         #1 chk("accept", 32'(e[8*i+7]), 32'(accept));
         chk("mask", 32'(e[8*i+5 +: 2]), 32'(mask));
         chk("fifo", 32'(e[8*i +: 5]), 32'(fifo));
      end
      @(posedge pclk);
      apb(1'b0, CTRL_OFFSET, 32'h0000_0000);
      chk("ctrl", e, rd);
   endtask
   initial begin
      {psel, penable, pwrite, presetn, paddr, pwdata, sel} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wr_chk(32'h0000_0000, 32'h0000_0000);
      wr_chk(32'h7f4a_2500, 32'h7f4a_2500);
      wr_chk(32'hffca_a580, 32'hffca_a580);
      wr_chk(32'h8080_8080, 32'hffca_a580);
      wr_chk(32'h0000_0000, 32'h7f4a_2500);
      wr_chk(32'h0000_0080, 32'h0000_0080);
      wr_chk(32'h1f1f_1f9f, 32'h1f1f_1f80);
      wr_chk(32'h0000_0000, 32'h0000_0000);
      apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
      chk("status", 32'h0000_000f, rd);
      apb(1'b1, STATUS_OFFSET, 32'h0000_000f);
      apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
      chk("status", 32'h0000_0000, rd);
      apb(1'b1, 12'h008, 32'hffff_ffff);
      chk("pslverr", 32'h0000_0000, 32'(slv));
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk("unmapped", 32'h0000_0000, rd);
      wr_chk(32'h0000_00a3, 32'h0000_00a3);
      // Mid-run reset must clear every filter output
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("enable", 32'h0000_0000, 32'(fen));
      chk("maskout", 32'h0000_0000, 32'(fmask));
      chk("fifoout", 32'h0000_0000, 32'(ffifo));
      presetn <= 1'b1;
      apb(1'b0, CTRL_OFFSET, 32'h0000_0000);
      chk("ctrl", 32'h0000_0000, rd);
      report_and_stop();
   end
endmodule // caf_filter_ctrl_tb
